/* File: rtl/sep_core.sv */
// Serial memory command port: decode, array, programming timer, data output
`timescale 1ns/100ps
module sep_core
	import sep_pkg::*;
#(
	parameter int PROG_CYCLES = SEP_PROG_CYC
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic chipSelect,
	input  wire logic serialClock,
	input  wire logic serialIn,
	input  wire logic programEnablePin,
	output      logic serialOut,
	output      logic serialOutEnN,
	output      logic busy
);
	localparam int FW = SEP_ADDR_W + SEP_DATA_W;

	// Reset release through two flops
	logic rstMeta_reg, rstN_reg;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstMeta_reg <= 1'b0;
			rstN_reg    <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN_reg    <= rstMeta_reg;
		end
	end

	// Pin synchronisers; logic uses the second stage and the edge-detect copies taken from it
	logic [3:0] pinMeta_reg;
	logic [3:0] pinSync_reg;
	logic       skPrev_reg;
	logic       csPrev_reg;
	always_ff @(posedge clock or negedge rstN_reg) begin
		if (!rstN_reg) begin
			pinMeta_reg <= 4'h8;
			pinSync_reg <= 4'h8;
			skPrev_reg  <= 1'b0;
			csPrev_reg  <= 1'b0;
		end else begin
			pinMeta_reg <= {programEnablePin, chipSelect, serialClock, serialIn};
			pinSync_reg <= pinMeta_reg;
			skPrev_reg  <= pinSync_reg[1];
			csPrev_reg  <= pinSync_reg[2];
		end
	end

	wire diS   = pinSync_reg[0];
	wire skS   = pinSync_reg[1];
	wire csS   = pinSync_reg[2];
	wire peS   = pinSync_reg[3];   // Pulled up, so a floating pin reads high
	wire skRise = skS && !skPrev_reg && csS;
	wire csFall = csPrev_reg && !csS;

	// Command state
	sep_state_t             state_reg, state_next;
	logic [SEP_CMD_W-1:0]   shift_reg;
	logic [3:0]             bitCnt_reg;
	logic [SEP_ADDR_W-1:0]  addr_reg;
	logic [SEP_DATA_W-1:0]  data_reg;
	logic                   wrEnable_reg;
	logic                   dout_reg;
	logic                   driving_reg;
	logic                   pendWrite_reg;

	logic [SEP_DATA_W-1:0]  mem [SEP_WORDS];
	logic [SEP_DATA_W-1:0]  rdWord;

	// Shift register holds start bit, opcode and address once full
	wire [SEP_CMD_W-1:0] cmdNext   = {shift_reg[SEP_CMD_W-2:0], diS};
	wire                 cmdFull   = cmdNext[SEP_CMD_W-1];
	wire [1:0]           opcode    = cmdNext[SEP_CMD_W-2 -: 2];
	wire [1:0]           subCode   = cmdNext[SEP_ADDR_W:SEP_ADDR_W-1];
	wire [SEP_ADDR_W-1:0] cmdAddr  = cmdNext[SEP_ADDR_W-1:0];
	wire                 isRead    = opcode == SEP_OP_READ;
	wire                 isWrite   = opcode == SEP_OP_WRITE;
	wire                 isEnable  = opcode == SEP_OP_SPECIAL && subCode == SEP_SUB_ENABLE;
	wire                 isDisable = opcode == SEP_OP_SPECIAL && subCode == SEP_SUB_DISABLE;
	wire                 progOk    = peS;
	wire                 writeOk   = wrEnable_reg && progOk;
	wire [SEP_ADDR_W-1:0] addrInc  = addr_reg + 1'b1;
	wire                 lastBit   = bitCnt_reg == SEP_CNT_LAST;

	// FIFO carries finished write words to the programming engine
	logic             fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
	logic [FW-1:0]    fifoOutData;
	logic [31:0]      progCnt_reg;
	logic             progActive_reg;

	assign rdWord = mem[addr_reg];
	// Write is queued on the falling select after all 16 data bits
	assign fifoInValid  = pendWrite_reg && csFall;
	// Word leaves the queue only when its timed cycle ends, so the store still sees it
	assign fifoOutReady = progActive_reg && progCnt_reg == '0;
	assign busy         = progActive_reg || fifoOutValid;

	sep_fifo #(
		.WIDTH (FW),
		.DEPTH (SEP_FIFO_DEPTH)
	) uFifo (
		.clock    (clock),
		.rstN     (rstN_reg),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   ({addr_reg, data_reg}),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// Next command state; a new write is refused while the queue is full
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SEP_IDLE: begin
				if (skRise && diS) state_next = SEP_CMD;   // Leading zeros skipped
			end
			SEP_CMD: begin
				if (skRise && cmdFull) begin
					if (isRead) state_next = SEP_DUMMY;
					else if (isWrite && writeOk && fifoInReady) state_next = SEP_WDATA;
					else state_next = SEP_DONE;
				end
			end
			SEP_DUMMY: state_next = SEP_RDATA;   // Dummy bit stands from the last address rise
			SEP_RDATA: state_next = SEP_RDATA;
			SEP_WDATA: begin
				if (skRise && lastBit) state_next = SEP_DONE;
			end
			SEP_DONE: state_next = SEP_DONE;
			default: state_next = SEP_IDLE;
		endcase
		if (!csS) state_next = SEP_IDLE;
	end

	// Command decode and serial shifting
	always_ff @(posedge clock or negedge rstN_reg) begin
		if (!rstN_reg) begin
			state_reg     <= SEP_IDLE;
			shift_reg     <= '0;
			bitCnt_reg    <= SEP_CNT_ZERO;
			addr_reg      <= '0;
			data_reg      <= '0;
			wrEnable_reg  <= 1'b0;
			pendWrite_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (!csS) begin
				shift_reg <= '0;
				bitCnt_reg <= SEP_CNT_ZERO;
			end else if (skRise) begin
				unique case (state_reg)
					SEP_IDLE: begin
						shift_reg <= {{(SEP_CMD_W-1){1'b0}}, diS};
						pendWrite_reg <= 1'b0;
					end
					SEP_CMD: begin
						shift_reg <= cmdNext;
						if (cmdFull) begin
							addr_reg <= cmdAddr;
							if (isEnable && progOk) wrEnable_reg <= 1'b1;
							if (isDisable && progOk) wrEnable_reg <= 1'b0;
						end
					end
					SEP_DUMMY: bitCnt_reg <= SEP_CNT_ZERO;
					SEP_RDATA: begin
						bitCnt_reg <= bitCnt_reg + 1'b1;
						if (lastBit) addr_reg <= addrInc;
					end
					SEP_WDATA: begin
						data_reg   <= {data_reg[SEP_DATA_W-2:0], diS};
						bitCnt_reg <= bitCnt_reg + 1'b1;
						if (lastBit) pendWrite_reg <= 1'b1;
					end
					default: ;
				endcase
			end
			// A clock edge after the last data bit cancels the write
			if (state_reg == SEP_DONE && skRise) pendWrite_reg <= 1'b0;
			if (fifoInValid) pendWrite_reg <= 1'b0;
		end
	end

	// Self-timed programming: erase and write collapse into one word store
	always_ff @(posedge clock or negedge rstN_reg) begin
		if (!rstN_reg) begin
			progActive_reg <= 1'b0;
			progCnt_reg    <= '0;
		end else if (!progActive_reg && fifoOutValid) begin
			progActive_reg <= 1'b1;
			progCnt_reg    <= 32'(PROG_CYCLES - 1);
		end else if (progActive_reg) begin
			if (progCnt_reg == '0) progActive_reg <= 1'b0;
			else progCnt_reg <= progCnt_reg - 1'b1;
		end
	end

	// Word store at the end of the timed cycle; contents undefined at power-up
	always_ff @(posedge clock) begin
		if (progActive_reg && progCnt_reg == '0) begin
			mem[fifoOutData[FW-1 -: SEP_ADDR_W]] <= fifoOutData[SEP_DATA_W-1:0];
		end
	end

	// Status is shown from select high after a write until the next start bit
	logic statusShow_reg;
	always_ff @(posedge clock or negedge rstN_reg) begin
		if (!rstN_reg) begin
			statusShow_reg <= 1'b0;
		end else if (fifoInValid) begin
			statusShow_reg <= 1'b1;
		end else if (skRise && state_reg == SEP_IDLE && diS) begin
			statusShow_reg <= 1'b0;
		end
	end

	// Output pin: read data changes on the rising serial clock; status after a write shows low while busy; floats otherwise
	always_ff @(posedge clock or negedge rstN_reg) begin
		if (!rstN_reg) begin
			dout_reg    <= 1'b0;
			driving_reg <= 1'b0;
		end else if (!csS) begin
			driving_reg <= 1'b0;
			dout_reg    <= 1'b0;
		end else if (state_reg == SEP_DUMMY || state_reg == SEP_RDATA) begin
			driving_reg <= 1'b1;
			if (state_reg == SEP_DUMMY) dout_reg <= 1'b0;
			if (skRise && state_reg == SEP_RDATA) begin
				dout_reg <= rdWord[SEP_CNT_LAST - bitCnt_reg];
			end
		end else if (statusShow_reg && state_reg == SEP_IDLE) begin
			driving_reg <= 1'b1;
			dout_reg    <= !busy;
		end else begin
			driving_reg <= 1'b0;
			dout_reg    <= 1'b0;
		end
	end

	assign serialOut    = dout_reg;
	assign serialOutEnN = !driving_reg;
endmodule

/* File: rtl/sep_pkg.sv */
// Package of constants for the serial memory command port
// Summary of operation
// - Memory holds 128 words of 16 bits, chosen by a seven-bit address.
// - Data input is sampled on each rising serial clock edge while selected.
// - Read data bits change on the rising serial clock edge.
// - Data output floats except while shifting read data or showing status.
// - After power-up the part is write-disabled without any command.
// - Writes are ignored while disabled; host must enable writes first.
// - Write-enabled state lasts until a write-disable command arrives.
// - Reads run whether writes are enabled or disabled.
// - An unconnected program enable pin reads high and permits programming commands.
// - A command is a start bit of one, two-bit opcode, then address.
// - A leading zero before the start bit is ignored.
// - Opcode 10 reads, 01 writes; address top bit ignored, low seven used.
// - Opcode 00 with address starting 11 enables writes.
// - Opcode 00 with address starting 00 disables writes.
// - Write carries 16 data bits; host drops select before the next clock edge.
// - Falling select after a write starts a self-timed erase and program cycle.
// - With select high after a write, output shows low while busy, high when ready.
// - Status shows only while select is high; output floats when select is low.
// - Status is driven until the start bit of the next command is sampled.
// - A read outputs one dummy zero bit, then 16 data bits.
// - Continued clocking reads the next word, wrapping from the top address to zero.
package sep_pkg;
	localparam int          SEP_WORDS       = 128;
	localparam int          SEP_DATA_W      = 16;
	localparam int          SEP_ADDR_W      = 7;
	localparam int          SEP_CMD_W       = 11;   // Start bit, two opcode bits, eight address bits
	localparam logic [1:0]  SEP_OP_READ     = 2'h1 << 1;
	localparam logic [1:0]  SEP_OP_WRITE    = 2'h1;
	localparam logic [1:0]  SEP_OP_SPECIAL  = 2'h0;
	localparam logic [1:0]  SEP_SUB_ENABLE  = 2'h3;
	localparam logic [1:0]  SEP_SUB_DISABLE = 2'h0;
	localparam int          SEP_CLK_HZ      = 40_000_000;
	localparam int          SEP_PROG_US     = 10;
	localparam int          SEP_PROG_CYC    = SEP_PROG_US * (SEP_CLK_HZ / 1_000_000);
	localparam int          SEP_FIFO_DEPTH  = 16;
	localparam logic [3:0]  SEP_CNT_ZERO    = 4'h0;
	localparam logic [3:0]  SEP_CNT_LAST    = 4'hF;

	typedef enum logic [2:0] {
		SEP_IDLE  = 3'h0,
		SEP_CMD   = 3'h1,
		SEP_DUMMY = 3'h2,
		SEP_RDATA = 3'h3,
		SEP_WDATA = 3'h4,
		SEP_DONE  = 3'h5
	} sep_state_t;
endpackage

/* File: rtl/sep_fifo.sv */
// Parameterised valid/ready FIFO for write words awaiting programming
`timescale 1ns/100ps
module sep_fifo #(
	parameter int WIDTH = 23,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rstN,
	input  wire logic             inValid,
	output      logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output      logic             outValid,
	input  wire logic             outReady,
	output      logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	wire              doPush = inValid && inReady;
	wire              doPop  = outValid && outReady;

	// Full and empty come straight from the occupancy count
	assign inReady  = count_reg != (AW+1)'(DEPTH);
	assign outValid = count_reg != '0;
	assign outData  = mem[rdPtr_reg];

	// Storage carries no reset so it can map to RAM
	always_ff @(posedge clock) begin
		if (doPush) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// Pointers wrap naturally for power-of-two depths
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doPush) wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doPop) rdPtr_reg <= rdPtr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end
endmodule

/* File: tb/sep_properties.sv */
// Pin-level concurrent checks of the serial memory command port
`timescale 1ns/100ps
module sep_properties #(
	parameter int PROG_CYCLES = 20
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic chipSelect,
	input wire logic serialClock,
	input wire logic serialIn,
	input wire logic programEnablePin,
	input wire logic serialOut,
	input wire logic serialOutEnN,
	input wire logic busy
);
	logic [15:0] busyLen_reg;
	logic [3:0]  skAge_reg;
	logic        skDly_reg;
	wire         skRise = serialClock && !skDly_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Busy spell length; age since a link clock rise, restarted by busy so status moves pass
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busyLen_reg <= 16'h0000;
			skAge_reg   <= 4'hF;
			skDly_reg   <= 1'b0;
		end else begin
			busyLen_reg <= busy ? busyLen_reg + 16'h0001 : 16'h0000;
			skAge_reg   <= (skRise || busy) ? 4'h0 : skAge_reg + {3'h0, skAge_reg != 4'hF};
			skDly_reg   <= serialClock;
		end
	end
	sequence deselected_s;
		!chipSelect [*6];
	endsequence
	sequence shows_status_s;
		chipSelect && !serialOutEnN;
	endsequence
	float_when_deselected_a: assert property (deselected_s |-> serialOutEnN)
		else $error("output driven while deselected");
	drive_needs_select_a: assert property ($fell(serialOutEnN) |-> chipSelect)
		else $error("output enabled without select");
	busy_shows_low_a: assert property (busy ##0 shows_status_s |-> !serialOut)
		else $error("status high while programming");
	ready_shows_high_a: assert property ($fell(busy) ##0 shows_status_s |-> ##[0:3] serialOut)
		else $error("ready status missing");
	prog_after_deselect_a: assert property ($rose(busy) |-> !chipSelect)
		else $error("programming began while selected");
	prog_min_time_a: assert property ($fell(busy) |-> busyLen_reg >= PROG_CYCLES)
		else $error("programming cycle too short");
	sk_paced_out_a: assert property ($changed(serialOut) && !serialOutEnN && !$past(serialOutEnN) |-> skAge_reg <= 4'h8)
		else $error("data output moved without a link clock rise");
	pin_blocks_prog_a: assert property (!programEnablePin && !busy |=> !busy)
		else $error("programming began with the protect pin low");
endmodule

/* File: tb/sep_host.sv */
// Host model driving the link pins as serial master
`timescale 1ns/100ps
module sep_host (
	output logic      chipSelect,
	output logic      serialClock,
	output logic      serialIn,
	input  wire logic dataLine
);
	// Link clock stands low outside frames
	initial begin
		chipSelect  = 1'b0;
		serialClock = 1'b0;
		serialIn    = 1'b0;
	end
	// Deselect flips the data input so a stale bit is never mistaken for a held one
	task automatic select(input logic v);
		chipSelect = v; // Drops before the next link clock rise
		if (!v) begin
			serialIn = ~serialIn;
			#250;
		end
	endtask
	// Bits go MSB first; the output is sampled 195 ns after each rise, 5 ns before the next bit is driven
	task automatic shift(input logic [47:0] d, input int n, output logic [47:0] q);
		q = 48'h0000_0000_0000;
		for (int i = n - 1; i >= 0; i--) begin
			serialIn = d[i];
			#100 serialClock = 1'b1;
			#100 serialClock = 1'b0;
			#95 q[i] = dataLine;
			#5;
		end
	endtask
	// One command; callers may send writes while writes are disabled and never send the reserved prefix
	task automatic frame(input logic [47:0] d, input int n, output logic [47:0] q);
		select(1'b1);
		#100 shift(d, n, q);
		select(1'b0);
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the serial memory command port
`timescale 1ns/100ps
module testbench;
	localparam int PROG = 20;
	logic        clock            = 1'b0;
	logic        nrst             = 1'b0;
	logic        programEnablePin = 1'b1;
	logic        chipSelect, serialClock, serialIn, serialOut, serialOutEnN, busy;
	logic [47:0] q;
	int          fails            = 0;
	int          n_checks         = 0;
	wire         dataLine         = serialOutEnN ? 1'bz : serialOut; // Enable is active low
	// Clock of 25 ns
	always #12.5 clock = ~clock;
	sep_core #(.PROG_CYCLES(PROG)) DUT (
		.clock(clock),
		.nrst(nrst),
		.chipSelect(chipSelect),
		.serialClock(serialClock),
		.serialIn(serialIn),
		.programEnablePin(programEnablePin),
		.serialOut(serialOut),
		.serialOutEnN(serialOutEnN),
		.busy(busy)
	);
	sep_host host (
		.chipSelect(chipSelect),
		.serialClock(serialClock),
		.serialIn(serialIn),
		.dataLine(dataLine)
	);
	// Value compare
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Status after a write is low while programming and stays high until a start bit
	task automatic await_ready();
		int i;
		host.select(1'b1);
		#150 cmp("busy status", 16'h0000, dataLine);
		for (i = 0; i < 400 && dataLine !== 1'b1; i++) begin
			#25;
		end
		if (i == 400) begin
			fails++;
			summarize();
		end
		host.shift(48'h0000_0000_0000, 1, q);
		cmp("held ready", 16'h0001, q[0]);
		host.select(1'b0);
	endtask
	// Writes refused at power-up and after an enable sent with the protect pin low
	task automatic locked_writes();
		cmp("idle output enable", 16'h0001, serialOutEnN);
		host.frame({3'h5, 8'h03, 16'h5A5A}, 27, q);
		cmp("busy after locked write", 16'h0000, busy);
		@(posedge clock);
		#1 programEnablePin = 1'b0;
		host.frame(48'h04C0, 11, q);
		@(posedge clock);
		#1 programEnablePin = 1'b1;
		host.frame({3'h5, 8'h03, 16'h5A5A}, 27, q);
		cmp("busy after refused enable", 16'h0000, busy);
	endtask
	// Enable after a leading zero, program two words, read across the wrap
	task automatic program_words();
		host.frame(48'h04C0, 12, q);
		host.frame({3'h5, 8'h7F, 16'h1234}, 27, q);
		await_ready();
		host.frame({3'h5, 8'h80, 16'hBEEF}, 27, q);
		await_ready();
		host.frame({3'h6, 8'hFF, 32'h0000_0000}, 43, q);
		cmp("dummy bit", 16'h0000, q[32]);
		cmp("word 7F", 16'h1234, q[31:16]);
		cmp("wrapped word 00", 16'hBEEF, q[15:0]);
	endtask
	// Disable blocks writes while reads go on
	task automatic disabled_writes();
		host.frame(48'h0400, 11, q);
		host.frame({3'h5, 8'h00, 16'h0F0F}, 27, q);
		cmp("busy while disabled", 16'h0000, busy);
		host.frame({3'h6, 8'h00, 16'h0000}, 27, q);
		cmp("word 00 kept", 16'hBEEF, q[15:0]);
		cmp("released output", 16'h000z, dataLine);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (6) @(posedge clock);
		locked_writes();
		program_words();
		disabled_writes();
		summarize();
	end
endmodule
bind sep_core sep_properties #(.PROG_CYCLES(PROG_CYCLES)) props (.clock(clock), .nrst(nrst),
	.chipSelect(chipSelect), .serialClock(serialClock), .serialIn(serialIn),
	.programEnablePin(programEnablePin), .serialOut(serialOut),
	.serialOutEnN(serialOutEnN), .busy(busy));
